// ===== common/strap_boot_map.svh
// register offsets, field positions and reset values of the strap loader
// assumes a 4-bit byte address and 32-bit read data
`ifndef STRAP_BOOT_MAP_SVH
`define STRAP_BOOT_MAP_SVH

`define STRAP_ADDR_W          4
`define STRAP_DATA_W          32
`define STRAP_PIN_N           3

// byte offsets
`define STRAP_VALUE_OFS       4'h0
`define STRAP_BOOT_STAT_OFS   4'h4
`define STRAP_RST_CAUSE_OFS   4'h8

// strap value fields
`define STRAP_FIRST_BIT       0
`define STRAP_SECOND_BIT      1
`define STRAP_DEBUG_BIT       2

// boot status fields
`define STAT_FLASH_BIT        0
`define STAT_DOWNLOAD_BIT     1
`define STAT_INVALID_BIT      2
`define STAT_PRINT_BIT        3
`define STAT_JTAG_BIT         4
`define STAT_IN_RESET_BIT     5

// reset cause fields
`define CAUSE_N               5
`define CAUSE_POR_BIT         0
`define CAUSE_RTC_WDT_BIT     1
`define CAUSE_BROWNOUT_BIT    2
`define CAUSE_SUPER_WDT_BIT   3
`define CAUSE_GLITCH_BIT      4

// latch reset values
`define STRAP_FIRST_RST       1'b0
`define STRAP_SECOND_RST      1'b1
`define STRAP_DEBUG_RST       1'b0

`endif

// ===== common/strap_boot_pkg.sv
// types shared by the strap loader
// no dependencies
package strap_boot_pkg;

  typedef enum logic [1:0] {
    BOOT_FLASH    = 2'b00,
    BOOT_DOWNLOAD = 2'b01,
    BOOT_INVALID  = 2'b10
  } boot_mode_t;

  typedef enum logic [1:0] {
    LOG_ALWAYS_ON   = 2'b00,
    LOG_ON_WHEN_LOW = 2'b01,
    LOG_ON_WHEN_HI  = 2'b10,
    LOG_ALWAYS_OFF  = 2'b11
  } rom_log_policy_t;

endpackage

// ===== hw/strap_pin_cell.sv
// one strap latch: samples its pin while a system reset is active
// assumes capture_in pulses in the first cycle after the reset ends
`timescale 1ns/100ps
`default_nettype none

module strap_pin_cell #(
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input  wire logic sys_clk_in,
  input  wire logic rst_n_in,
  // control
  input  wire logic sample_in,
  input  wire logic capture_in,
  // pin and held value
  input  wire logic pin_in,
  output logic      value_out
);

  logic shadow_reg;
  logic value_reg;

  // follows the pin each cycle of reset
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shadow_reg <= RST_VAL;
    end else if (sample_in) begin
      shadow_reg <= pin_in;
    end
  end

  // takes the last in-reset level, then holds
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      value_reg <= RST_VAL;
    end else if (capture_in) begin
      value_reg <= shadow_reg;
    end
  end

  assign value_out = value_reg;

endmodule

`default_nettype wire

// ===== hw/strap_boot_config.sv
// strap pin boot configuration loader: latches, decode, register port
// assumes pins and fuses synchronous to sys_clk_in; rst_n_in is power-down
//
// Our own choices: the plain strobed port and the address map.
`include "strap_boot_map.svh"
`timescale 1ns/100ps
`default_nettype none

module strap_boot_config (
  // clock and reset
  input  wire logic                     sys_clk_in,
  input  wire logic                     rst_n_in,
  // reset causes
  input  wire logic                     chip_enable_pin_in,
  input  wire logic                     rtc_wdt_reset_in,
  input  wire logic                     brownout_reset_in,
  input  wire logic                     super_wdt_reset_in,
  input  wire logic                     xtal_glitch_reset_in,
  // strap pins
  input  wire logic                     boot_select_first_pin_in,
  input  wire logic                     boot_select_second_pin_in,
  input  wire logic                     boot_select_second_driven_in,
  input  wire logic                     debug_source_pin_in,
  output logic                          second_pin_pullup_en_out,
  output logic                          pin_release_out,
  // fuses
  input  wire logic [1:0]               rom_log_policy_fuse_in,
  input  wire logic                     debug_source_select_enable_fuse_in,
  // decoded boot configuration
  output logic                          boot_flash_out,
  output logic                          boot_download_out,
  output logic                          strap_invalid_out,
  output logic                          rom_print_en_out,
  output logic                          jtag_pin_source_out,
  // register port
  input  wire logic [`STRAP_ADDR_W-1:0] reg_addr_in,
  input  wire logic [`STRAP_DATA_W-1:0] reg_wdata_in,
  input  wire logic                     reg_wr_in,
  input  wire logic                     reg_rd_in,
  output logic      [`STRAP_DATA_W-1:0] reg_rdata_out
);

  logic [`CAUSE_N-1:0]       cause_now;
  logic                      sys_rst_active;
  logic                      sys_rst_q_reg;
  logic                      capture_edge;
  logic [`STRAP_PIN_N-1:0]   pins_eff;
  logic [`STRAP_PIN_N-1:0]   strap_bits;
  logic                      second_pullup_reg;
  logic                      release_reg;
  strap_boot_pkg::boot_mode_t boot_mode_next;
  logic [2:0]                mode_reg;
  logic                      print_next;
  logic                      print_reg;
  logic                      jtag_next;
  logic                      jtag_reg;
  logic [`CAUSE_N-1:0]       cause_reg;
  logic [`CAUSE_N-1:0]       cause_next;
  logic [`STRAP_DATA_W-1:0]  rdata_next;
  logic [`STRAP_DATA_W-1:0]  rdata_reg;

  // any system reset source; chip enable low is the power-on reset
  assign cause_now[`CAUSE_POR_BIT]       = !chip_enable_pin_in;
  assign cause_now[`CAUSE_RTC_WDT_BIT]   = rtc_wdt_reset_in;
  assign cause_now[`CAUSE_BROWNOUT_BIT]  = brownout_reset_in;
  assign cause_now[`CAUSE_SUPER_WDT_BIT] = super_wdt_reset_in;
  assign cause_now[`CAUSE_GLITCH_BIT]    = xtal_glitch_reset_in;
  assign sys_rst_active = |cause_now;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sys_rst_q_reg <= 1'b1;
    end else begin
      sys_rst_q_reg <= sys_rst_active;
    end
  end

  // first cycle out of reset: latch update instant
  assign capture_edge = sys_rst_q_reg && !sys_rst_active;

  // undriven second pin resolves through the weak pull-up
  assign pins_eff[`STRAP_FIRST_BIT]  = boot_select_first_pin_in;
  assign pins_eff[`STRAP_SECOND_BIT] = boot_select_second_driven_in ?
                                       boot_select_second_pin_in :
                                       second_pullup_reg;
  assign pins_eff[`STRAP_DEBUG_BIT]  = debug_source_pin_in;

  // one latch per strap pin
  strap_pin_cell #(.RST_VAL(`STRAP_FIRST_RST)) u_first (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .sample_in  (sys_rst_active),
    .capture_in (capture_edge),
    .pin_in     (pins_eff[`STRAP_FIRST_BIT]),
    .value_out  (strap_bits[`STRAP_FIRST_BIT])
  );

  strap_pin_cell #(.RST_VAL(`STRAP_SECOND_RST)) u_second (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .sample_in  (sys_rst_active),
    .capture_in (capture_edge),
    .pin_in     (pins_eff[`STRAP_SECOND_BIT]),
    .value_out  (strap_bits[`STRAP_SECOND_BIT])
  );

  strap_pin_cell #(.RST_VAL(`STRAP_DEBUG_RST)) u_debug (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .sample_in  (sys_rst_active),
    .capture_in (capture_edge),
    .pin_in     (pins_eff[`STRAP_DEBUG_BIT]),
    .value_out  (strap_bits[`STRAP_DEBUG_BIT])
  );

  // pad control: pull-up on by default, pins freed after reset
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      second_pullup_reg <= 1'b1;
    end else begin
      second_pullup_reg <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      release_reg <= 1'b0;
    end else begin
      release_reg <= !sys_rst_active;
    end
  end

  // boot mode decode; both zero is left flagged, not acted on
  always_comb begin
    if (strap_bits[`STRAP_SECOND_BIT]) begin
      boot_mode_next = strap_boot_pkg::BOOT_FLASH;
    end else if (strap_bits[`STRAP_FIRST_BIT]) begin
      boot_mode_next = strap_boot_pkg::BOOT_DOWNLOAD;
    end else begin
      boot_mode_next = strap_boot_pkg::BOOT_INVALID;
    end
  end

  // rom log print decode
  always_comb begin
    case (strap_boot_pkg::rom_log_policy_t'(rom_log_policy_fuse_in))
      strap_boot_pkg::LOG_ALWAYS_ON: begin
        print_next = 1'b1;
      end
      strap_boot_pkg::LOG_ON_WHEN_LOW: begin
        print_next = !strap_bits[`STRAP_FIRST_BIT];
      end
      strap_boot_pkg::LOG_ON_WHEN_HI: begin
        print_next = strap_bits[`STRAP_FIRST_BIT];
      end
      strap_boot_pkg::LOG_ALWAYS_OFF: begin
        print_next = 1'b0;
      end
      default: begin
        print_next = 1'b0;
      end
    endcase
  end

  // jtag source decode
  always_comb begin
    if (!debug_source_select_enable_fuse_in) begin
      jtag_next = 1'b0;
    end else begin
      jtag_next = !strap_bits[`STRAP_DEBUG_BIT];
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_reg      <= 3'h1;
      print_reg     <= 1'b0;
      jtag_reg      <= 1'b0;
    end else begin
      mode_reg      <= {boot_mode_next == strap_boot_pkg::BOOT_INVALID,
                        boot_mode_next == strap_boot_pkg::BOOT_DOWNLOAD,
                        boot_mode_next == strap_boot_pkg::BOOT_FLASH};
      print_reg     <= print_next;
      jtag_reg      <= jtag_next;
    end
  end

  // sticky reset causes, write one to clear, set wins
  always_comb begin
    cause_next = cause_reg;
    if (reg_wr_in && reg_addr_in == `STRAP_RST_CAUSE_OFS) begin
      cause_next = cause_next & ~reg_wdata_in[`CAUSE_N-1:0];
    end
    cause_next = cause_next | cause_now;
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cause_reg <= '0;
    end else begin
      cause_reg <= cause_next;
    end
  end

  // read mux; strap value has no write path at all
  always_comb begin
    rdata_next = '0;
    if (reg_rd_in) begin
      case (reg_addr_in)
        `STRAP_VALUE_OFS: begin
          rdata_next[`STRAP_PIN_N-1:0] = strap_bits;
        end
        `STRAP_BOOT_STAT_OFS: begin
          rdata_next[`STAT_FLASH_BIT]    = boot_flash_out;
          rdata_next[`STAT_DOWNLOAD_BIT] = boot_download_out;
          rdata_next[`STAT_INVALID_BIT]  = strap_invalid_out;
          rdata_next[`STAT_PRINT_BIT]    = print_reg;
          rdata_next[`STAT_JTAG_BIT]     = jtag_reg;
          rdata_next[`STAT_IN_RESET_BIT] = !release_reg;
        end
        `STRAP_RST_CAUSE_OFS: begin
          rdata_next[`CAUSE_N-1:0] = cause_reg;
        end
        default: begin
          rdata_next = '0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign second_pin_pullup_en_out = second_pullup_reg;
  assign pin_release_out          = release_reg;
  assign boot_flash_out           = mode_reg[0];
  assign boot_download_out        = mode_reg[1];
  assign strap_invalid_out        = mode_reg[2];
  assign rom_print_en_out         = print_reg;
  assign jtag_pin_source_out      = jtag_reg;
  assign reg_rdata_out            = rdata_reg;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence reset_tail;
    sys_rst_active ##1 !sys_rst_active;
  endsequence

  sequence quiet_cycle;
    !capture_edge;
  endsequence

  a_latch_capture: assert property (
    reset_tail |=> strap_bits == $past(pins_eff, 2))
    else $error("strap latch missed last in-reset pin level");
  a_latch_sample: assert property (
    sys_rst_active ##1 sys_rst_active ##1 !sys_rst_active
      |=> strap_bits == $past(pins_eff, 2))
    else $error("strap latch not sampled during reset");
  a_latch_hold: assert property (
    quiet_cycle |=> $stable(strap_bits))
    else $error("strap bits changed outside capture");
  a_cause_recapture: assert property (
    (|cause_now) |=> sys_rst_q_reg &&
      (cause_reg & $past(cause_now)) == $past(cause_now))
    else $error("reset cause not seen as system reset");
  a_strap_read: assert property (
    reg_rd_in && reg_addr_in == `STRAP_VALUE_OFS
      |=> reg_rdata_out == {29'h0000000, $past(strap_bits)})
    else $error("strap value read wrong");
  a_pin_release: assert property (
    sys_rst_active ##1 !sys_rst_active |-> !pin_release_out ##1 pin_release_out)
    else $error("pins not released after reset");
  a_pullup_default: assert property (
    !boot_select_second_driven_in && sys_rst_active ##1 !sys_rst_active
      |=> strap_bits[`STRAP_SECOND_BIT] && second_pin_pullup_en_out)
    else $error("undriven second pin not captured as one");
  a_boot_flash: assert property (
    strap_bits[`STRAP_SECOND_BIT] |=> boot_flash_out && !boot_download_out)
    else $error("flash boot not decoded");
  a_boot_download: assert property (
    strap_bits[`STRAP_FIRST_BIT] && !strap_bits[`STRAP_SECOND_BIT]
      |=> boot_download_out && !boot_flash_out)
    else $error("download boot not decoded");
  a_print_on: assert property (
    rom_log_policy_fuse_in == 2'h0 |=> rom_print_en_out)
    else $error("print not forced on");
  a_print_low: assert property (
    rom_log_policy_fuse_in == 2'h1
      |=> rom_print_en_out == !$past(strap_bits[`STRAP_FIRST_BIT]))
    else $error("print policy one wrong");
  a_print_high: assert property (
    rom_log_policy_fuse_in == 2'h2
      |=> rom_print_en_out == $past(strap_bits[`STRAP_FIRST_BIT]))
    else $error("print policy two wrong");
  a_print_off: assert property (
    rom_log_policy_fuse_in == 2'h3 |=> !rom_print_en_out)
    else $error("print not forced off");
  a_jtag_blocked: assert property (
    !debug_source_select_enable_fuse_in |=> !jtag_pin_source_out)
    else $error("jtag usable with fuse clear");
  a_jtag_select: assert property (
    debug_source_select_enable_fuse_in
      |=> jtag_pin_source_out == !$past(strap_bits[`STRAP_DEBUG_BIT]))
    else $error("jtag source decode wrong");
  a_write_ignored: assert property (
    reg_wr_in && reg_addr_in == `STRAP_VALUE_OFS && !capture_edge
      |=> $stable(strap_bits))
    else $error("write altered strap bits");

endmodule

`default_nettype wire

// ===== test/board_strap_model.sv
// board side of the strap pins: resistors or a host driving the levels
// assumes want_* inputs change just after a rising clock edge
`timescale 1ns/100ps
`default_nettype none

module board_strap_model (
  // clock and reset
  input  wire logic sys_clk_in,
  input  wire logic rst_n_in,
  // wanted board levels
  input  wire logic power_on_in,
  input  wire logic want_first_in,
  input  wire logic want_second_in,
  input  wire logic want_debug_in,
  input  wire logic float_second_in,
  // from the device
  input  wire logic pin_release_in,
  input  wire logic pullup_en_in,
  // pins
  output logic      chip_enable_out,
  output logic      first_pin_out,
  output logic      second_pin_out,
  output logic      second_driven_out,
  output logic      debug_pin_out
);
  logic tog_reg;
  logic second_want;

  // ordinary pin traffic once the device lets go of the straps
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tog_reg <= 1'b0;
    end else begin
      tog_reg <= ~tog_reg;
    end
  end

  // both boot pins low is never strapped
  assign second_want = want_second_in | ~want_first_in;
  assign chip_enable_out = power_on_in;

  always_comb begin
    if (pin_release_in) begin
      first_pin_out     = tog_reg;
      second_pin_out    = ~tog_reg;
      second_driven_out = 1'b1;
      debug_pin_out     = tog_reg;
    end else begin
      first_pin_out     = want_first_in;
      debug_pin_out     = want_debug_in;
      second_driven_out = ~float_second_in;
      // floating pin follows the pull-up, else a changing level
      if (float_second_in) begin
        second_pin_out = pullup_en_in ? 1'b1 : tog_reg;
      end else begin
        second_pin_out = second_want;
      end
    end
  end
endmodule

`default_nettype wire

// ===== test/tb_strap_pin_boot_config.sv
// self-checking bench of the strap loader through its register port and its decoded outputs
// assumes the board model drives the strap pins and chip enable
`include "strap_boot_map.svh"
`timescale 1ns/100ps
`default_nettype none

module tb_strap_pin_boot_config;
  logic        clk, rst_n, float2, dbg_fuse;
  logic [4:0]  cause_vec;
  logic [2:0]  want;
  logic [1:0]  policy;
  logic        ce, p1, p2, p2_drv, pd, pull, rel;
  logic        flash, dnld, inval, prn, jtag, wr, rd;
  logic [3:0]  addr;
  logic [31:0] wdata, rdata, got;
  int          num_errors, comparisons, cycles;
  logic [2:0]  tbl [5] = '{3'b001, 3'b110, 3'b011, 3'b100, 3'b010};

  board_strap_model i_board (
    .sys_clk_in(clk), .rst_n_in(rst_n), .power_on_in(~cause_vec[0]),
    .want_first_in(want[0]), .want_second_in(want[1]),
    .want_debug_in(want[2]), .float_second_in(float2),
    .pin_release_in(rel), .pullup_en_in(pull), .chip_enable_out(ce),
    .first_pin_out(p1), .second_pin_out(p2), .second_driven_out(p2_drv),
    .debug_pin_out(pd));

  strap_boot_config i_dut (
    .sys_clk_in(clk), .rst_n_in(rst_n), .chip_enable_pin_in(ce),
    .rtc_wdt_reset_in(cause_vec[1]), .brownout_reset_in(cause_vec[2]),
    .super_wdt_reset_in(cause_vec[3]), .xtal_glitch_reset_in(cause_vec[4]),
    .boot_select_first_pin_in(p1), .boot_select_second_pin_in(p2),
    .boot_select_second_driven_in(p2_drv), .debug_source_pin_in(pd),
    .second_pin_pullup_en_out(pull), .pin_release_out(rel),
    .rom_log_policy_fuse_in(policy),
    .debug_source_select_enable_fuse_in(dbg_fuse),
    .boot_flash_out(flash), .boot_download_out(dnld),
    .strap_invalid_out(inval), .rom_print_en_out(prn),
    .jtag_pin_source_out(jtag), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // end a system reset and wait for the decoded outputs to settle
  task automatic release_cause();
    @(posedge clk);
    cause_vec <= 5'h00;
    for (int i = 0; i < 20 && rel !== 1'b1; i++) @(posedge clk);
    repeat (4) @(posedge clk);
  endtask

  // wrong levels during reset, wanted ones only in the last cycle
  task automatic capture(input int c, input logic [2:0] b, input logic f);
    logic [2:0] e;
    e = {b[2], b[1] | f, b[0]};
    @(posedge clk);
    cause_vec <= 5'h01 << c; want <= ~b; float2 <= 1'b0;
    repeat (4) @(posedge clk);
    want <= b; float2 <= f;
    #1 check({31'h0, rel}, 32'h0);
    release_cause();
    check({31'h0, rel}, 32'h1);
    reg_read(`STRAP_VALUE_OFS, got);
    check(got, {29'h0, e});
    check({30'h0, flash, dnld}, {30'h0, e[1], e[0] & ~e[1]});
    check({31'h0, inval}, 32'h0);
    repeat (10) @(posedge clk);
    reg_read(`STRAP_VALUE_OFS, got);
    check(got, {29'h0, e});
  endtask

  task automatic fuse_sweep(input logic first, input logic dbg);
    logic exp_p;
    for (int p = 0; p < 4; p++) begin
      for (int j = 0; j < 2; j++) begin
        @(posedge clk);
        policy <= 2'(p); dbg_fuse <= j[0];
        repeat (2) @(posedge clk);
        #1 exp_p = (p == 0) | (p == 1 & ~first) | (p == 2 & first);
        check({31'h0, prn}, {31'h0, exp_p});
        check({31'h0, jtag}, {31'h0, j[0] & ~dbg});
      end
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      conclude();
    end
  end

  initial begin
    rst_n = 1'b0; cause_vec = 5'h01; want = 3'b010; float2 = 1'b0;
    policy = 2'h0; dbg_fuse = 1'b0; wr = 1'b0; rd = 1'b0;
    addr = 4'h0; wdata = 32'h0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    release_cause();
    check({31'h0, pull}, 32'h1);
    reg_read(`STRAP_VALUE_OFS, got);
    check(got, 32'h2);
    $display("test power-up done");
    for (int i = 0; i < 5; i++) capture(i, tbl[i], i == 3);
    $display("test reset causes done");
    reg_write(`STRAP_VALUE_OFS, 32'hFFFFFFFF);
    reg_write(`STRAP_BOOT_STAT_OFS, 32'hFFFFFFFF);
    reg_read(`STRAP_VALUE_OFS, got);
    check(got, 32'h2);
    check({30'h0, flash, dnld}, 32'h2);
    reg_read(4'hC, got);
    check(got, 32'h0);
    reg_read(`STRAP_BOOT_STAT_OFS, got);
    check(got, 32'h09);
    @(posedge clk);
    #1 check(rdata, 32'h0);
    reg_read(`STRAP_RST_CAUSE_OFS, got);
    check(got, 32'h1F);
    reg_write(`STRAP_RST_CAUSE_OFS, 32'h1F);
    reg_read(`STRAP_RST_CAUSE_OFS, got);
    check(got, 32'h0);
    $display("test read-only done");
    capture(1, 3'b010, 1'b0);
    fuse_sweep(1'b0, 1'b0);
    capture(2, 3'b111, 1'b0);
    fuse_sweep(1'b1, 1'b1);
    $display("test fuses done");
    conclude();
  end
endmodule

`default_nettype wire
